// ---- rtl/wit_top.sv ----
// Watchdog interval timer with AXI4-Lite register slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module wit_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic interval_irq_o,
    output logic wdt_reset_o,
    output logic wdt_reset_ext_o
);
    typedef struct packed {
        logic [11:0] awaddr;
        logic aw_ok;
        logic [7:0] wdata;
        logic wlane;
        logic w_ok;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [11:0] pre;
        logic tick_d;
        logic [7:0] count;
        logic ovf;
        logic ovf_armed;
        logic mode;
        logic en;
        logic [2:0] cks;
        logic watchdog_reset_flag;
        logic reset_output_enable;
        logic irq;
        logic wdt_rst;
    } wit_state_t;

    wit_state_t st_r;
    wit_state_t st_nxt;
    logic tap;
    logic tick;
    logic wr_go;

    // Prescaler tap selection
    always_comb begin
        unique case (st_r.cks)
            3'h0: tap = st_r.pre[0];
            3'h1: tap = st_r.pre[4];
            3'h2: tap = st_r.pre[5];
            3'h3: tap = st_r.pre[6];
            3'h4: tap = st_r.pre[7];
            3'h5: tap = st_r.pre[8];
            3'h6: tap = st_r.pre[10];
            3'h7: tap = st_r.pre[11];
        endcase
    end

    // Falling edge of tap gives one tick per divided period
    assign tick = st_r.tick_d & ~tap;
    assign wr_go = st_r.aw_ok & st_r.w_ok & ~st_r.bvalid;
    assign s_axi_awready = ~st_r.aw_ok & ~st_r.bvalid;
    assign s_axi_wready = ~st_r.w_ok & ~st_r.bvalid;
    assign s_axi_arready = ~st_r.rvalid;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rdata = {24'h000000, st_r.rdata};
    assign interval_irq_o = st_r.irq;
    assign wdt_reset_o = st_r.wdt_rst;
    assign wdt_reset_ext_o = st_r.wdt_rst & st_r.reset_output_enable;

    // Next state of bus slave and timer
    always_comb begin
        logic wrap;
        logic ovf_set;
        wrap = 1'b0;
        ovf_set = 1'b0;
        st_nxt = st_r;
        st_nxt.irq = 1'b0;
        st_nxt.wdt_rst = 1'b0;
        st_nxt.pre = st_r.pre + 12'h001;
        st_nxt.tick_d = tap;
        // Counter
        if (!st_r.en) begin
            st_nxt.count = wit_pkg::WIT_COUNT_RST;
            st_nxt.pre = 12'h000;
            st_nxt.tick_d = 1'b0;
        end else if (tick) begin
            st_nxt.count = st_r.count + 8'h01;
            wrap = (st_r.count == wit_pkg::WIT_COUNT_MAX);
        end
        // Write channels
        if (s_axi_awready && s_axi_awvalid) begin
            st_nxt.aw_ok = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wready && s_axi_wvalid) begin
            st_nxt.w_ok = 1'b1;
            st_nxt.wdata = s_axi_wdata[7:0];
            st_nxt.wlane = s_axi_wstrb[0];
        end
        if (wr_go) begin
            st_nxt.aw_ok = 1'b0;
            st_nxt.w_ok = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wit_pkg::WIT_RESP_OKAY;
            unique case (st_r.awaddr)
                wit_pkg::WIT_ADDR_CTRL: if (st_r.wlane) begin
                    st_nxt.mode = st_r.wdata[wit_pkg::WIT_CTRL_MODE];
                    st_nxt.en = st_r.wdata[wit_pkg::WIT_CTRL_EN];
                    st_nxt.cks = st_r.wdata[2:0];
                    // Zero clears only after flag read as one
                    if (!st_r.wdata[wit_pkg::WIT_CTRL_OVF] && st_r.ovf_armed) begin
                        st_nxt.ovf = 1'b0;
                        st_nxt.ovf_armed = 1'b0;
                    end
                end
                wit_pkg::WIT_ADDR_COUNT: if (st_r.wlane && st_r.en) begin
                    st_nxt.count = st_r.wdata;
                end
                wit_pkg::WIT_ADDR_RSTCS: if (st_r.wlane) begin
                    st_nxt.reset_output_enable = st_r.wdata[wit_pkg::WIT_RST_OE];
                    if (!st_r.wdata[wit_pkg::WIT_RST_FLAG]) begin
                        st_nxt.watchdog_reset_flag = 1'b0;
                    end
                end
                default: st_nxt.bresp = wit_pkg::WIT_RESP_SLVERR;
            endcase
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        // Read channel
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arready && s_axi_arvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = wit_pkg::WIT_RESP_OKAY;
            unique case (s_axi_araddr)
                wit_pkg::WIT_ADDR_CTRL: begin
                    st_nxt.rdata = wit_pkg::WIT_CTRL_RSVD
                        | {st_r.ovf, st_r.mode, st_r.en, 2'h0, st_r.cks};
                    if (st_r.ovf) begin
                        st_nxt.ovf_armed = 1'b1;
                    end
                end
                wit_pkg::WIT_ADDR_COUNT: st_nxt.rdata = st_r.count;
                wit_pkg::WIT_ADDR_RSTCS: st_nxt.rdata = wit_pkg::WIT_RSTCS_RSVD
                    | {st_r.watchdog_reset_flag, st_r.reset_output_enable, 6'h00};
                default: begin
                    st_nxt.rdata = 8'h00;
                    st_nxt.rresp = wit_pkg::WIT_RESP_SLVERR;
                end
            endcase
        end
        // Overflow effects, set wins over clear
        ovf_set = wrap;
        if (ovf_set) begin
            st_nxt.ovf = 1'b1;
            if (st_r.mode) begin
                st_nxt.wdt_rst = 1'b1;
                st_nxt.watchdog_reset_flag = 1'b1;
            end else begin
                st_nxt.irq = 1'b1;
            end
        end
    end

    // State register with clock enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end
endmodule : wit_top
`default_nettype wire

// ---- common/wit_pkg.sv ----
// Package with register map, field positions and reset values of the watchdog interval timer
package wit_pkg;
    // Register indices; the byte address of each register is its index times four
    localparam logic [7:0] WIT_IDX_CTRL = 8'ha8;
    localparam logic [7:0] WIT_IDX_COUNT = 8'ha9;
    localparam logic [7:0] WIT_IDX_RSTCS = 8'hab;
    localparam logic [11:0] WIT_ADDR_CTRL = {2'h0, WIT_IDX_CTRL, 2'h0};
    localparam logic [11:0] WIT_ADDR_COUNT = {2'h0, WIT_IDX_COUNT, 2'h0};
    localparam logic [11:0] WIT_ADDR_RSTCS = {2'h0, WIT_IDX_RSTCS, 2'h0};
    // Control/status field positions
    localparam int WIT_CTRL_OVF = 7;
    localparam int WIT_CTRL_MODE = 6;
    localparam int WIT_CTRL_EN = 5;
    localparam int WIT_RST_FLAG = 7;
    localparam int WIT_RST_OE = 6;
    // Reserved bits read as one
    localparam logic [7:0] WIT_CTRL_RSVD = 8'h18;
    localparam logic [7:0] WIT_RSTCS_RSVD = 8'h3f;
    localparam logic [7:0] WIT_COUNT_RST = 8'h00;
    localparam logic [7:0] WIT_COUNT_MAX = 8'hff;
    localparam int WIT_PRE_W = 12;
    // AXI responses
    localparam logic [1:0] WIT_RESP_OKAY = 2'h0;
    localparam logic [1:0] WIT_RESP_SLVERR = 2'h2;
endpackage : wit_pkg

// ---- dv/wit_props.sv ----
// Port assertions for the watchdog interval timer
`timescale 1ns/1ns
`default_nettype none
module wit_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic interval_irq_o,
    input wire logic wdt_reset_o,
    input wire logic wdt_reset_ext_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Event outputs
    AST_EXT_NEEDS_WDT: assert property (wdt_reset_ext_o |-> wdt_reset_o)
        else $error("external reset without watchdog reset");
    AST_MODE_EXCL: assert property (!(interval_irq_o && wdt_reset_o))
        else $error("interrupt and reset together");
    AST_IRQ_PULSE: assert property (interval_irq_o && ce_i |=> !interval_irq_o)
        else $error("interrupt pulse too long");
    AST_WDT_PULSE: assert property (wdt_reset_o && ce_i |=> !wdt_reset_o)
        else $error("reset pulse too long");
    // Bus answers stand until taken, read data carries one byte, no read is taken while one is pending
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    AST_R_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    // Main scenarios
    COV_IRQ: cover property (interval_irq_o);
    COV_EXT: cover property (wdt_reset_ext_o);
    COV_WR: cover property (s_axi_bvalid && s_axi_bready);
endmodule : wit_props
bind wit_top wit_props u_props (.*);
`default_nettype wire

// ---- dv/wit_top_test.sv ----
// Register-level bench for the watchdog interval timer
`timescale 1ns/1ns
`default_nettype none
module wit_top_test;
    localparam logic [11:0] AC = wit_pkg::WIT_ADDR_CTRL;
    localparam logic [11:0] AN = wit_pkg::WIT_ADDR_COUNT;
    localparam logic [11:0] AR = wit_pkg::WIT_ADDR_RSTCS;
    logic clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic interval_irq_o, wdt_reset_o, wdt_reset_ext_o;
    logic [7:0] v;
    int failures = 0, samples_checked = 0, n, c;
    int dv[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
    int irq_n = 0, wdt_n = 0, ext_n = 0;
    always #20 clk_i = ~clk_i;
    // Pulse counters for the event outputs
    always @(posedge clk_i) begin
        irq_n <= irq_n + int'(interval_irq_o);
        wdt_n <= wdt_n + int'(wdt_reset_o);
        ext_n <= ext_n + int'(wdt_reset_ext_o);
    end
    wit_top dut (.*);
    // Byte compare
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Verdict and end of run
    task automatic final_report();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    // Hung wait counts as mismatch
    task automatic hang();
        failures++;
        final_report();
    endtask : hang
    // Bus write of one byte
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; !s_axi_bvalid; n++) begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (n > 40) hang();
        end
        s_axi_bready <= 1'h0;
    endtask : wr
    // Bus read of one byte
    task automatic rd(input logic [11:0] a);
        @(posedge clk_i);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (n = 0; !s_axi_rvalid; n++) begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (n > 40) hang();
        end
        v = s_axi_rdata[7:0];
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : rd
    // Wait for interrupt or watchdog reset, counting cycles
    task automatic ev(input bit w);
        for (c = 0; !(w ? wdt_reset_o : interval_irq_o); c++) begin
            @(posedge clk_i);
            if (c > 20000) hang();
        end
    endtask : ev
    // Test sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        rd(AC); chk(v, 8'h18);
        rd(AN); chk(v, 8'h00);
        rd(AR); chk(v, 8'h3f);
        rd(12'h0); chk({6'h0, rsp}, {6'h0, wit_pkg::WIT_RESP_SLVERR});
        $display("reset values done");
        for (int k = 0; k < 8; k++) begin
            wr(AC, 8'h00);
            wr(AC, {5'h04, 3'(k)});
            wr(AN, 8'hfe);
            ev(0);
            wr(AN, 8'hfe);
            ev(0);
            chk(8'(c > dv[k] && c <= 2 * dv[k] + 2), 8'h01);
        end
        $display("clock select done");
        wr(AC, 8'h27);
        rd(AC); chk(v, 8'hbf);
        wr(AC, 8'hbf);
        rd(AC); chk(v, 8'hbf);
        wr(AC, 8'h27);
        rd(AC); chk(v, 8'h3f);
        chk(8'(irq_n), 8'h10);
        chk(8'(wdt_n), 8'h00);
        wr(AC, 8'h00);
        wr(AN, 8'h55);
        rd(AN); chk(v, 8'h00);
        $display("flag and hold done");
        wr(AR, 8'h40);
        wr(AC, 8'h60);
        wr(AN, 8'hfe);
        ev(1);
        wr(AC, 8'h40);
        rd(AR); chk(v, 8'hff);
        wr(AR, 8'hc0);
        rd(AR); chk(v, 8'hff);
        wr(AR, 8'h00);
        rd(AR); chk(v, 8'h3f);
        wr(AC, 8'h60);
        wr(AN, 8'hfe);
        ev(1);
        wr(AC, 8'h40);
        rd(AR); chk(v, 8'hbf);
        chk(8'(wdt_n), 8'h02);
        chk(8'(ext_n), 8'h01);
        chk(8'(irq_n), 8'h10);
        $display("watchdog done");
        final_report();
    end
endmodule : wit_top_test
`default_nettype wire
